// ===== dssl_top.sv
// Drive strap select block: APB strap register, status readback, registered outputs.
// Assumes APB signals and host lines are synchronous to CLOCK_IN.
`timescale 1ns/10ps
module dssl_top #(
  parameter int LINES = 4,
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic CLOCK_IN,
  input wire logic RST_B_IN,
  // APB slave
  input wire logic PSEL_IN,
  input wire logic PENABLE_IN,
  input wire logic PWRITE_IN,
  input wire logic [ADDR_W-1:0] PADDR_IN,
  input wire logic [31:0] PWDATA_IN,
  input wire logic [3:0] PSTRB_IN,
  output logic [31:0] PRDATA_OUT,
  output logic PREADY_OUT,
  output logic PSLVERR_OUT,
  // Host lines
  input wire logic [LINES-1:0] SELECT_IN,
  input wire logic MOTOR_ON_IN,
  // Drive controls
  output logic DRIVE_SELECTED_OUT,
  output logic HEAD_LOAD_OUT,
  output logic STEPPER_POWER_OUT,
  output logic SIDE_OUT
);

  // Reset release
  logic rst_meta_q;
  logic rst_sync_q;
  logic rst_n;

  always_ff @(posedge CLOCK_IN or negedge RST_B_IN) begin
    if (!RST_B_IN) begin
      rst_meta_q <= 1'b0;
      rst_sync_q <= 1'b0;
    end else begin
      rst_meta_q <= 1'b1;
      rst_sync_q <= rst_meta_q;
    end
  end

  assign rst_n = rst_sync_q;

  // Strap register and bus answer
  logic [dssl_pkg::STRAP_W-1:0] strap_q;
  logic [dssl_pkg::STRAP_W-1:0] strap_d;
  logic [31:0] prdata_q;
  logic [31:0] prdata_d;
  logic pready_q;
  logic pready_d;
  logic pslverr_q;
  logic pslverr_d;

  // Decode results
  logic sel_c;
  logic head_c;
  logic step_c;
  logic side_c;
  logic sel_q;
  logic head_q;
  logic step_q;
  logic side_q;

  logic setup;
  logic commit;
  logic hit_strap;
  logic hit_status;
  logic [31:0] status_word;
  logic [31:0] strap_word;

  dssl_logic #(
    .LINES(LINES)
  ) u_logic (
    .select_strap_in(strap_q[dssl_pkg::SEL_LSB +: LINES]),
    .head_load_from_select_strap_in(strap_q[dssl_pkg::HS_BIT]),
    .head_load_from_motor_strap_in(strap_q[dssl_pkg::HM_BIT]),
    .force_select_strap_in(strap_q[dssl_pkg::FORCE_BIT]),
    .side_pad_line_one_in(strap_q[dssl_pkg::PAD1_BIT]),
    .side_pad_line_three_in(strap_q[dssl_pkg::PAD3_BIT]),
    .step_mode_in(strap_q[dssl_pkg::STEP_LSB +: 2]),
    .select_in(SELECT_IN),
    .motor_on_in(MOTOR_ON_IN),
    .selected_out(sel_c),
    .head_load_out(head_c),
    .stepper_power_out(step_c),
    .side_out(side_c)
  );

  assign setup = PSEL_IN & ~PENABLE_IN;
  assign commit = PSEL_IN & PENABLE_IN & pready_q;
  assign hit_strap = (PADDR_IN == dssl_pkg::STRAP_OFFSET);
  assign hit_status = (PADDR_IN == dssl_pkg::STATUS_OFFSET);

  always_comb begin
    strap_word = 32'h0000_0000;
    strap_word[dssl_pkg::STRAP_W-1:0] = strap_q;
    status_word = 32'h0000_0000;
    status_word[dssl_pkg::ST_SELECTED_BIT] = sel_q;
    status_word[dssl_pkg::ST_HEAD_BIT] = head_q;
    status_word[dssl_pkg::ST_STEP_BIT] = step_q;
    status_word[dssl_pkg::ST_SIDE_BIT] = side_q;
    status_word[dssl_pkg::ST_SELIN_LSB +: LINES] = SELECT_IN;
    status_word[dssl_pkg::ST_MOTOR_BIT] = MOTOR_ON_IN;
  end

  // Answer in the first access cycle; data and error are prepared during setup
  always_comb begin
    pready_d = setup;
    pslverr_d = 1'b0;
    prdata_d = 32'h0000_0000;
    strap_d = strap_q;
    if (setup) begin
      if (hit_strap) begin
        prdata_d = PWRITE_IN ? 32'h0000_0000 : strap_word;
      end else if (hit_status) begin
        prdata_d = PWRITE_IN ? 32'h0000_0000 : status_word;
        pslverr_d = PWRITE_IN;
      end else begin
        pslverr_d = 1'b1;
      end
    end
    // Byte lanes 0 and 1 carry the straps; other lanes hold nothing
    if (commit && PWRITE_IN && hit_strap) begin
      if (PSTRB_IN[0]) begin
        strap_d[7:0] = PWDATA_IN[7:0];
      end
      if (PSTRB_IN[1]) begin
        strap_d[dssl_pkg::STRAP_W-1:8] = PWDATA_IN[dssl_pkg::STRAP_W-1:8];
      end
    end
  end

  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      strap_q <= dssl_pkg::STRAP_RESET;
      prdata_q <= 32'h0000_0000;
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      strap_q <= strap_d;
      prdata_q <= prdata_d;
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
    end
  end

  // Outputs are registered copies of the decode, so they trail inputs by one cycle
  always_ff @(posedge CLOCK_IN or negedge rst_n) begin
    if (!rst_n) begin
      sel_q <= 1'b0;
      head_q <= 1'b0;
      step_q <= 1'b0;
      side_q <= 1'b0;
    end else begin
      sel_q <= sel_c;
      head_q <= head_c;
      step_q <= step_c;
      side_q <= side_c;
    end
  end

  assign PRDATA_OUT = prdata_q;
  assign PREADY_OUT = pready_q;
  assign PSLVERR_OUT = pslverr_q;
  assign DRIVE_SELECTED_OUT = sel_q;
  assign HEAD_LOAD_OUT = head_q;
  assign STEPPER_POWER_OUT = step_q;
  assign SIDE_OUT = side_q;

  // Checks
  logic [1:0] smode;
  logic [LINES-1:0] sstrap;
  assign smode = strap_q[dssl_pkg::STEP_LSB +: 2];
  assign sstrap = strap_q[dssl_pkg::SEL_LSB +: LINES];

  property p_strap_select;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (|(sstrap & SELECT_IN)) |=> DRIVE_SELECTED_OUT;
  endproperty
  a_strap_select: assert property (p_strap_select)
    else $error("Strapped active select line did not select the drive");

  property p_open_strap;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (!strap_q[dssl_pkg::FORCE_BIT] && !(|(sstrap & SELECT_IN))) |=> !DRIVE_SELECTED_OUT;
  endproperty
  a_open_strap: assert property (p_open_strap)
    else $error("Drive selected without a strapped active line");

  property p_force;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    strap_q[dssl_pkg::FORCE_BIT] [*2] |-> DRIVE_SELECTED_OUT;
  endproperty
  a_force: assert property (p_force)
    else $error("Force strap did not hold the drive selected");

  property p_head_select;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (strap_q[dssl_pkg::HS_BIT] && (|SELECT_IN)) |=> HEAD_LOAD_OUT;
  endproperty
  a_head_select: assert property (p_head_select)
    else $error("Head not loaded on select");

  property p_head_motor;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (strap_q[dssl_pkg::HM_BIT] && !strap_q[dssl_pkg::HS_BIT])
      |=> (HEAD_LOAD_OUT == $past(MOTOR_ON_IN));
  endproperty
  a_head_motor: assert property (p_head_motor)
    else $error("Head load does not follow motor-on");

  property p_head_idle;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (!strap_q[dssl_pkg::HM_BIT] && !(strap_q[dssl_pkg::HS_BIT] && (|SELECT_IN)))
      |=> !HEAD_LOAD_OUT;
  endproperty
  a_head_idle: assert property (p_head_idle)
    else $error("Head loaded without cause");

  property p_step_motor;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (smode == dssl_pkg::STEP_MOTOR) |=> (STEPPER_POWER_OUT == $past(MOTOR_ON_IN));
  endproperty
  a_step_motor: assert property (p_step_motor)
    else $error("Stepper power does not follow motor-on");

  property p_step_select;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (smode == dssl_pkg::STEP_SELECT) |=> (STEPPER_POWER_OUT == $past(|SELECT_IN));
  endproperty
  a_step_select: assert property (p_step_select)
    else $error("Stepper power does not follow select");

  property p_step_always;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (smode == dssl_pkg::STEP_ALWAYS) |=> STEPPER_POWER_OUT [*1];
  endproperty
  a_step_always: assert property (p_step_always)
    else $error("Stepper power dropped with no jumper");

  property p_side_one;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    strap_q[dssl_pkg::PAD1_BIT] |=> (SIDE_OUT == !$past(SELECT_IN[1]));
  endproperty
  a_side_one: assert property (p_side_one)
    else $error("Side choice from line one wrong");

  property p_side_three;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (!strap_q[dssl_pkg::PAD1_BIT] && strap_q[dssl_pkg::PAD3_BIT])
      |=> (SIDE_OUT == !$past(SELECT_IN[3]));
  endproperty
  a_side_three: assert property (p_side_three)
    else $error("Side choice from line three wrong");

  property p_factory;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    $rose(rst_n) |-> (strap_q == dssl_pkg::STRAP_RESET);
  endproperty
  a_factory: assert property (p_factory)
    else $error("Straps not at factory setting after reset");

  property p_apb_answer;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (PSEL_IN && !PENABLE_IN) |=> PREADY_OUT ##1 !PREADY_OUT;
  endproperty
  a_apb_answer: assert property (p_apb_answer)
    else $error("APB answer not exactly one cycle after setup");

  property p_apb_write;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (commit && PWRITE_IN && hit_strap && (&PSTRB_IN[1:0]))
      |=> (strap_q == $past(PWDATA_IN[dssl_pkg::STRAP_W-1:0]));
  endproperty
  a_apb_write: assert property (p_apb_write)
    else $error("Strap write not applied");

  property p_lane_low;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (commit && PWRITE_IN && hit_strap && !PSTRB_IN[0])
      |=> (strap_q[7:0] == $past(strap_q[7:0]));
  endproperty
  a_lane_low: assert property (p_lane_low)
    else $error("Strap low byte changed with its strobe off");

  property p_lane_high;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (commit && PWRITE_IN && hit_strap && !PSTRB_IN[1])
      |=> (strap_q[dssl_pkg::STRAP_W-1:8] == $past(strap_q[dssl_pkg::STRAP_W-1:8]));
  endproperty
  a_lane_high: assert property (p_lane_high)
    else $error("Strap high bits changed with their strobe off");

  // Straps are configuration: nothing but a strap write or reset may move them
  property p_strap_hold;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    !(commit && PWRITE_IN && hit_strap) |=> $stable(strap_q);
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("Straps changed without a strap write");

  property p_step_other;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    ((smode != dssl_pkg::STEP_MOTOR) && (smode != dssl_pkg::STEP_SELECT))
      |=> STEPPER_POWER_OUT;
  endproperty
  a_step_other: assert property (p_step_other)
    else $error("Stepper power dropped in an unjumpered mode");

  property p_side_none;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (!strap_q[dssl_pkg::PAD1_BIT] && !strap_q[dssl_pkg::PAD3_BIT]) |=> !SIDE_OUT;
  endproperty
  a_side_none: assert property (p_side_none)
    else $error("Side output set with no side pad tied");

  property p_status_err;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (setup && hit_status && PWRITE_IN) |=> PSLVERR_OUT;
  endproperty
  a_status_err: assert property (p_status_err)
    else $error("Write to status not refused");

  property p_unmapped;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (setup && !hit_strap && !hit_status)
      |=> (PSLVERR_OUT && (PRDATA_OUT == 32'h0000_0000));
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("Unmapped access not refused");

  property p_read_strap;
    @(posedge CLOCK_IN) disable iff (!rst_n)
    (setup && !PWRITE_IN && hit_strap)
      |=> (PRDATA_OUT[dssl_pkg::STRAP_W-1:0] == $past(strap_q));
  endproperty
  a_read_strap: assert property (p_read_strap)
    else $error("Strap read data wrong");

  c_side_mode: cover property (@(posedge CLOCK_IN) disable iff (!rst_n)
    strap_q[dssl_pkg::PAD1_BIT] && !SELECT_IN[1] ##1 SIDE_OUT);
  c_head_motor: cover property (@(posedge CLOCK_IN) disable iff (!rst_n)
    strap_q[dssl_pkg::HM_BIT] && MOTOR_ON_IN ##1 HEAD_LOAD_OUT);
  c_step_select: cover property (@(posedge CLOCK_IN) disable iff (!rst_n)
    (smode == dssl_pkg::STEP_SELECT) && (|SELECT_IN) ##1 STEPPER_POWER_OUT);
  c_unmapped: cover property (@(posedge CLOCK_IN) disable iff (!rst_n) PSLVERR_OUT);

endmodule

// ===== dssl_pkg.sv
// Constants for the drive strap select logic: register map, strap fields, reset values.
// Assumes a 32-bit APB master reaches the strap and status registers.
// Function
// - A shorted select strap lets its select line select the drive; an open one ignores it.
// - The force-select strap selects the drive whatever the select lines do.
// - The head-load-from-select strap loads the head while any select line is active.
// - With the motor strap shorted and the select strap open the head loads on motor-on.
// - In the factory stepper mode stepper power follows motor-on.
// - In the first alternative stepper mode any active select line powers the stepper.
// - With no stepper jumper fitted the stepper stays powered all the time.
// - In side-select mode a low side line picks side 1 and a high level side 0.
// - A single drive using side select opens select strap 1 and ties the line-one side pad.
// - A second drive using side select opens select strap 3 and ties the line-three side pad.
// - Reset: select straps and select head-load shorted, motor head-load open, stepper on motor.
package dssl_pkg;

  // Register byte offsets
  localparam logic [11:0] STRAP_OFFSET = 12'h000;
  localparam logic [11:0] STATUS_OFFSET = 12'h004;

  // Strap register layout
  localparam int STRAP_W = 11;
  localparam int SEL_LSB = 0;
  localparam int HS_BIT = 4;
  localparam int HM_BIT = 5;
  localparam int FORCE_BIT = 6;
  localparam int PAD1_BIT = 7;
  localparam int PAD3_BIT = 8;
  localparam int STEP_LSB = 9;
  localparam logic [STRAP_W-1:0] STRAP_RESET = 11'h01f;

  // Stepper power modes
  localparam logic [1:0] STEP_MOTOR = 2'h0;
  localparam logic [1:0] STEP_SELECT = 2'h1;
  localparam logic [1:0] STEP_ALWAYS = 2'h2;

  // Status register layout
  localparam int ST_SELECTED_BIT = 0;
  localparam int ST_HEAD_BIT = 1;
  localparam int ST_STEP_BIT = 2;
  localparam int ST_SIDE_BIT = 3;
  localparam int ST_SELIN_LSB = 4;
  localparam int ST_MOTOR_BIT = 8;

endpackage

// ===== dssl_logic.sv
// Combinational strap decode for the drive select logic.
// Assumes straps are quasi-static and select lines are active high.
`timescale 1ns/10ps
module dssl_logic #(
  parameter int LINES = 4
) (
  // Straps
  input wire logic [LINES-1:0] select_strap_in,
  input wire logic head_load_from_select_strap_in,
  input wire logic head_load_from_motor_strap_in,
  input wire logic force_select_strap_in,
  input wire logic side_pad_line_one_in,
  input wire logic side_pad_line_three_in,
  input wire logic [1:0] step_mode_in,
  // Host lines
  input wire logic [LINES-1:0] select_in,
  input wire logic motor_on_in,
  // Results
  output logic selected_out,
  output logic head_load_out,
  output logic stepper_power_out,
  output logic side_out
);

  logic [LINES-1:0] gated;
  logic any_select;

  genvar i;
  generate
    for (i = 0; i < LINES; i++) begin : g_line
      assign gated[i] = select_strap_in[i] & select_in[i];
    end
  endgenerate

  assign any_select = |select_in;

  always_comb begin
    selected_out = force_select_strap_in | (|gated);
    head_load_out = (head_load_from_select_strap_in & any_select)
      | (head_load_from_motor_strap_in & ~head_load_from_select_strap_in & motor_on_in);
    case (step_mode_in)
      dssl_pkg::STEP_MOTOR: stepper_power_out = motor_on_in;
      dssl_pkg::STEP_SELECT: stepper_power_out = any_select;
      default: stepper_power_out = 1'b1;
    endcase
    // Line one wins if both pads are tied; a drive normally ties only one
    if (side_pad_line_one_in) begin
      side_out = ~select_in[1];
    end else if (side_pad_line_three_in) begin
      side_out = ~select_in[3];
    end else begin
      side_out = 1'b0;
    end
  end

endmodule

// ===== dssl_host.sv
// Host controller model: drives the four select lines and motor-on toward the drive.
// Assumes the bench hands it requests synchronous to the clock; lines change after an edge.
`timescale 1ns/10ps
module dssl_host (
  // Clock and reset
  input wire logic clk_in,
  input wire logic rst_b_in,
  // Requests from the bench
  input wire logic [3:0] sel_req_in,
  input wire logic motor_req_in,
  // Lines to the drive
  output logic [3:0] select_out,
  output logic motor_on_out
);
  logic [3:0] select_d;
  logic [3:0] select_q;
  logic motor_d;
  logic motor_q;

  // Lines one and three may carry a side choice as a plain level
  always_comb begin
    select_d = sel_req_in;
    motor_d = motor_req_in;
  end

  always_ff @(posedge clk_in or negedge rst_b_in) begin
    if (!rst_b_in) begin
      select_q <= 4'h0;
      motor_q <= 1'b0;
    end else begin
      select_q <= select_d;
      motor_q <= motor_d;
    end
  end

  assign select_out = select_q;
  assign motor_on_out = motor_q;
endmodule

// ===== tb.sv
// Self-checking bench: APB strap writes, random host line levels, output and status checks.
// Assumes the design answers APB with zero wait states and registers its outputs.
`timescale 1ns/10ps
module tb;
  logic clk, rst_b, psel, penable, pwrite, motor_req, motor_on;
  logic dsel, head, step, side, pready, pslverr, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [3:0] sel_req, select, pstrb;
  logic [10:0] s;
  int bad_count, tests_run, seed_v;
  logic [10:0] corners [10] = '{11'h01f, 11'h040, 11'h020, 11'h21f, 11'h41f,
                                11'h61f, 11'h09d, 11'h117, 11'h197, 11'h000};

  dssl_top #(.LINES(4), .ADDR_W(12)) u_dssl_top (.CLOCK_IN(clk), .RST_B_IN(rst_b),
    .PSEL_IN(psel), .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr),
    .PWDATA_IN(pwdata), .PSTRB_IN(pstrb), .PRDATA_OUT(prdata), .PREADY_OUT(pready),
    .PSLVERR_OUT(pslverr), .SELECT_IN(select), .MOTOR_ON_IN(motor_on),
    .DRIVE_SELECTED_OUT(dsel), .HEAD_LOAD_OUT(head), .STEPPER_POWER_OUT(step),
    .SIDE_OUT(side));

  dssl_host u_dssl_host (.clk_in(clk), .rst_b_in(rst_b), .sel_req_in(sel_req),
    .motor_req_in(motor_req), .select_out(select), .motor_on_out(motor_on));

  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  // Packs {side, stepper, head, selected}; the motor head-load trace counts only with the
  // select head-load trace open
  function automatic logic [3:0] expect_out(logic [10:0] t, logic [3:0] sl, logic m);
    logic any;
    logic sd;
    any = |sl;
    sd = t[7] ? ~sl[1] : (t[8] ? ~sl[3] : 1'b0);
    return {sd, (t[10:9] == 2'h0) ? m : ((t[10:9] == 2'h1) ? any : 1'b1),
            (t[4] & any) | (t[5] & ~t[4] & m), (|(sl & t[3:0])) | t[6]};
  endfunction

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [11:0] a, input logic [31:0] d,
           output logic [31:0] r, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task apply(input logic [10:0] t, input logic [3:0] sl, input logic m);
    logic [3:0] e;
    apb(1'b1, 12'h000, {21'h0, t}, rd, err);
    sel_req <= sl;
    motor_req <= m;
    e = expect_out(t, sl, m);
    repeat (3) @(posedge clk);
    chk({28'h0, side, step, head, dsel}, {28'h0, e});
    apb(1'b0, 12'h004, 32'h0, rd, err);
    chk(rd, {23'h0, m, sl, e});
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, {21'h0, t});
  endtask

  task summarize;
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // About 200 transfers of a few cycles each; this leaves a wide margin
  initial begin
    #200000;
    bad_count++;
    summarize;
  end

  initial begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    sel_req = 4'h0;
    motor_req = 1'b0;
    pstrb = 4'hf;
    bad_count = 0;
    tests_run = 0;
    seed_v = $urandom(31751);
    repeat (4) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk({28'h0, side, step, head, dsel}, 32'h0);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0000_001f);
    apb(1'b0, 12'h008, 32'h0, rd, err);
    chk({rd[30:0], err}, 32'h1);
    apb(1'b1, 12'h004, 32'hffff_ffff, rd, err);
    chk({31'h0, err}, 32'h1);
    apb(1'b1, 12'h000, 32'hffff_ffff, rd, err);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0000_07ff);
    pstrb <= 4'h2;
    apb(1'b1, 12'h000, 32'h0000_00aa, rd, err);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0000_00ff);
    pstrb <= 4'h1;
    apb(1'b1, 12'h000, 32'h0000_0510, rd, err);
    pstrb <= 4'hf;
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0000_0010);
    for (int i = 0; i < 60; i++) begin
      if (i < 10) begin
        s = corners[i];
      end else begin
        s = 11'($urandom);
      end
      apply(s, 4'($urandom), 1'($urandom));
    end
    rst_b <= 1'b0;
    sel_req <= 4'h0;
    motor_req <= 1'b0;
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk);
    chk({28'h0, side, step, head, dsel}, 32'h0);
    apb(1'b0, 12'h000, 32'h0, rd, err);
    chk(rd, 32'h0000_001f);
    summarize;
  end
endmodule
